// File: design/serial_tx_defs.vh
// Constants for the displayed value serial transmitter.
`ifndef SERIAL_TX_DEFS_VH
`define SERIAL_TX_DEFS_VH
`define CLOCK_HZ        10000000
`define BAUD_RATE       2400
`define BIT_CYCLES      (`CLOCK_HZ / `BAUD_RATE)
`define DATA_BITS       7
`define STOP_BITS       2
`define CHAR_BITS       4'd11
`define FRAME_CHARS     12
`define CH_CR           7'h0d
`define CH_LF           7'h0a
`define CH_COMMA        7'h2c
`define CH_PLUS         7'h2b
`define CH_MINUS        7'h2d
`define CH_POINT        7'h2e
`define CH_ZERO         7'h30
`define CH_NINE         7'h39
`define CH_W            7'h57
`define CH_T            7'h54
`define CH_O            7'h4f
`define CH_L            7'h4c
`endif

// File: design/frame_store.v
// Twelve-entry character store whose read data come out of a register.
`default_nettype none
module frame_store #(
    parameter DEPTH = 12,
    parameter AW    = 4
) (
    // Clock.
    input  wire          clock,
    // Write port.
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [6:0]    wr_data,
    // Read port.
    input  wire [AW-1:0] rd_addr,
    output reg  [6:0]    rd_data
);
    reg [6:0] mem [0:DEPTH-1]; // Character cells.

    // Write and registered read; storage needs no reset.
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// File: design/displayed_value_serial_tx.v
// Transmit-only serial formatter for the displayed measurement value.
//
// Functional notes
// - Send one frame per sample; samples arriving mid-frame give one more frame.
// - Transmit only; received characters are ignored.
// - Only digits, capitals, fixed punctuation and CR LF characters.
// - Asynchronous characters at 2400 bps, start bit.
// - Seven data bits, even parity, two stops.
// - Rate and format fixed, not configurable.
`include "serial_tx_defs.vh"
`default_nettype none
module displayed_value_serial_tx #(
    parameter BIT_CYCLES = `BIT_CYCLES
) (
    // Clock and reset.
    input  wire        clock,
    input  wire        reset_n,
    // Displayed value, sampled when the frame requested by sample_done starts.
    input  wire        sample_done,
    input  wire        value_negative,
    input  wire [23:0] value_bcd,
    input  wire [2:0]  point_pos,
    input  wire        overload,
    // Serial line.
    input  wire        rx_line,
    output reg         tx_line,
    output wire        busy
);
    // States of the sender, in binary; one pass of the loop sends one frame.
    localparam ST_IDLE = 2'd0; // Line high, waiting for a sample.
    localparam ST_LOAD = 2'd1; // Writing the twelve cells into the store.
    localparam ST_WAIT = 2'd2; // Letting the read data of the store settle.
    localparam ST_SEND = 2'd3; // Shifting one character onto the line.

    // Sequencer and character bookkeeping.
    reg [1:0]  state_r;       // Sequencer state.
    reg        pending_r;     // A new sample waits for the line.
    reg [3:0]  fill_idx_r;    // Cell being written while building.
    reg        filling_r;     // Frame is being built into the store.
    reg [3:0]  char_idx_r;    // Character being sent.
    reg [10:0] shift_r;       // Outgoing character, LSB first.
    reg [3:0]  bit_cnt_r;     // Bits left in the character.
    reg [15:0] baud_r;        // Bit-time counter.
    reg        wait_r;        // Read address has settled; data valid next clock.
    // Sample latched when a frame starts, so that a change of the inputs
    // in mid-frame can never mix two samples into one frame.
    reg        neg_r;         // Latched sign.
    reg [23:0] val_r;         // Latched digits.
    reg [2:0]  pt_r;          // Latched decimal point position.
    reg        ovl_r;         // Latched overload.
    // Character path between the frame builder and the store.
    reg [6:0]  cell_nxt;      // Character for the cell being built.
    wire [6:0] rd_data;       // Character read from the store.

    // The receive pin is tied to nothing on purpose: the link carries no
    // commands, so whatever arrives there can never steer the sender.
    wire unused_rx = rx_line;

    // Busy covers the build as well as the send, so a frame is seen to be
    // in progress from the clock after its sample is taken to its last stop.
    assign busy = (state_r != ST_IDLE) | filling_r;

    // Six value positions, left to right. The point position counts the
    // digits that stand right of the point, so the point takes cell 5 - pt
    // and the most significant digit drops out of the frame to make room.
    // With no point all six digits show, leading zeros included.
    function [6:0] value_char;
        input [3:0]  pos; // Value cell, 0 at the left.
        input [23:0] v;   // Six BCD digits, rightmost in the low nibble.
        input [2:0]  pt;  // Digits right of the point, 0 for none.
        input        ovl; // Overload shows nines in every digit cell.
        reg   [3:0]  di;  // Digit index, 0 for the rightmost digit.
        begin
            di = 4'h0;
            if (pt != 3'd0 && pos == 4'd5 - {1'b0, pt}) begin
                // The point keeps its place on overload too.
                value_char = `CH_POINT;
            end else if (ovl) begin
                value_char = `CH_NINE;
            end else begin
                // Digit index counts from the right, skipping the point cell.
                if (pt != 3'd0 && pos < 4'd5 - {1'b0, pt}) begin
                    // Left of the point: one digit further right than the cell.
                    di = 4'd4 - pos;
                end else begin
                    // Right of the point, or no point at all.
                    di = 4'd5 - pos;
                end
                // Valid BCD digits give only '0' to '9' here, never a letter.
                value_char = `CH_ZERO | {3'h0, v[di*4 +: 4]};
            end
        end
    endfunction

    // Character for each frame cell, built one cell a clock from the
    // latched sample; the header tells a receiver at once whether the
    // value is good or an overload.
    always @* begin
        case (fill_idx_r)
            4'd0:    cell_nxt = ovl_r ? `CH_O : `CH_W;
            4'd1:    cell_nxt = ovl_r ? `CH_L : `CH_T;
            4'd2:    cell_nxt = `CH_COMMA;
            4'd3:    cell_nxt = neg_r ? `CH_MINUS : `CH_PLUS;
            4'd10:   cell_nxt = `CH_CR;
            4'd11:   cell_nxt = `CH_LF;
            default: cell_nxt = value_char(fill_idx_r - 4'd4, val_r, pt_r, ovl_r);
        endcase
    end

    // The frame is built once into the store and then read out cell by
    // cell, so a sample that changes while the line is busy cannot reach it.
    frame_store #(
        .DEPTH (`FRAME_CHARS),
        .AW    (4)
    ) u_store (
        .clock   (clock),
        .wr_en   (filling_r),
        .wr_addr (fill_idx_r),
        .wr_data (cell_nxt),
        .rd_addr (char_idx_r),
        .rd_data (rd_data)
    );

    // Sequencer: a sample seen mid-frame is held and sent next, so the
    // stream never tears a frame; only the latest sample is kept.
    // The trade-off is that a receiver may miss samples when the sampling
    // period is shorter than a frame, which takes 12 x 11 bit times; it
    // always sees whole, current frames instead.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r    <= ST_IDLE;
            pending_r  <= 1'b0;
            fill_idx_r <= 4'h0;
            filling_r  <= 1'b0;
            char_idx_r <= 4'h0;
            shift_r    <= 11'h7ff;
            bit_cnt_r  <= 4'h0;
            baud_r     <= 16'h0;
            neg_r      <= 1'b0;
            val_r      <= 24'h0;
            pt_r       <= 3'h0;
            ovl_r      <= 1'b0;
            // The line idles high so the receiver sees no false start bit.
            tx_line    <= 1'b1;
            wait_r     <= 1'b0;
        end else begin
            // A sample pulse always raises pending, whatever the state.
            if (sample_done) begin
                pending_r <= 1'b1;
            end
            case (state_r)
                ST_IDLE: begin
                    // Between frames the line rests at the stop level.
                    tx_line <= 1'b1;
                    // Take the sample standing now and start building.
                    if (pending_r && !filling_r) begin
                        pending_r  <= sample_done; // Set wins over clear.
                        neg_r      <= value_negative;
                        val_r      <= value_bcd;
                        pt_r       <= (point_pos > 3'd5) ? 3'd0 : point_pos;
                        ovl_r      <= overload;
                        filling_r  <= 1'b1;
                        fill_idx_r <= 4'h0;
                        state_r    <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // Build the frame one cell per clock; the store writes the
                    // cell at fill_idx_r on each of these twelve clocks.
                    if (fill_idx_r == `FRAME_CHARS - 1) begin
                        // Last cell written: stop writing, read from the first.
                        filling_r  <= 1'b0;
                        char_idx_r <= 4'h0;
                        state_r    <= ST_WAIT;
                    end else begin
                        fill_idx_r <= fill_idx_r + 4'h1;
                    end
                end
                ST_WAIT: begin
                    // The store answers one clock after its address, and the
                    // index moved on the edge that entered this state, so the
                    // first clock here only lets the read data catch up.
                    if (wait_r) begin
                        // Frame the character: start, data LSB first, even
                        // parity over the seven data bits, then two stops.
                        shift_r   <= {2'b11, ^rd_data, rd_data, 1'b0};
                        bit_cnt_r <= `CHAR_BITS;
                        baud_r    <= 16'h0;
                        wait_r    <= 1'b0;
                        state_r   <= ST_SEND;
                    end else begin
                        // Address stable now; the data is valid next clock.
                        wait_r <= 1'b1;
                    end
                end
                ST_SEND: begin
                    // The line is registered, so it follows the shifter one
                    // clock late; every bit lasts BIT_CYCLES clocks, the second stop two more between characters.
                    tx_line <= shift_r[0];
                    // End of a bit time: shift in a stop-level one behind.
                    if (baud_r == BIT_CYCLES - 1) begin
                        baud_r    <= 16'h0;
                        shift_r   <= {1'b1, shift_r[10:1]};
                        bit_cnt_r <= bit_cnt_r - 4'h1;
                        // Second stop bit done: next character or end of frame.
                        if (bit_cnt_r == 4'h1) begin
                            if (char_idx_r == `FRAME_CHARS - 1) begin
                                state_r <= ST_IDLE;
                            end else begin
                                char_idx_r <= char_idx_r + 4'h1;
                                state_r    <= ST_WAIT;
                            end
                        end
                    end else begin
                        baud_r <= baud_r + 16'h1;
                    end
                end
                // All four codes are states; the default only sends an unknown state to idle.
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: tb/serial_tx_chk.sv
// Concurrent checks on the serial transmitter ports.
`default_nettype none
module serial_tx_chk #(parameter BIT_CYCLES = 8) (
    // Clock, reset and frame request.
    input wire logic clock,
    input wire logic reset_n,
    input wire logic sample_done,
    // Serial output and frame flag.
    input wire logic tx_line,
    input wire logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // Repeat counts assume the shortened bit time of eight cycles.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    AST_IDLE: assert property (!busy |-> tx_line) else $error("line low when idle");
    AST_START: assert property ($fell(tx_line) |-> busy) else $error("low outside frame");
    AST_LOW_BIT: assert property ($fell(tx_line) |=> !tx_line [*7]) else $error("short low");
    AST_HIGH_BIT: assert property ($rose(tx_line) |=> tx_line [*7]) else $error("short high");
    AST_REQ: assert property (sample_done && !busy |-> ##[1:3] busy) else $error("no frame");
    AST_FIRST: assert property ($rose(busy) |-> ##[2:20] !tx_line) else $error("late start");
    AST_HOLD: assert property ($rose(busy) |-> busy [*8]) else $error("frame cut short");
    AST_END: assert property ($fell(busy) |-> tx_line && $past(tx_line, 8)) else $error("stop");
endmodule
bind displayed_value_serial_tx serial_tx_chk #(.BIT_CYCLES(BIT_CYCLES)) i_chk (
    .clock(clock), .reset_n(reset_n), .sample_done(sample_done), .tx_line(tx_line), .busy(busy));
`default_nettype wire

// File: tb/serial_rx_model.sv
// Receiver model that decodes characters from the serial line.
`default_nettype none
module serial_rx_model #(parameter BIT = 8) (
    // Clock and the line it listens to.
    input wire logic clock,
    input wire logic line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] got[$]; // Bit 7 marks clean framing, bits 6:0 hold the character.
    logic [6:0] c;      // Character being gathered.
    logic       ok;     // Framing and parity were good.
    // Sampling mid-bit tolerates a little edge skew, like a real receiver.
    always begin
        @(negedge line);
        repeat (BIT / 2) @(posedge clock);
        ok = !line;
        for (int i = 0; i < 7; i++) begin
            repeat (BIT) @(posedge clock);
            c[i] = line;
        end
        repeat (BIT) @(posedge clock);
        ok &= (line == ^c);
        repeat (2) begin
            repeat (BIT) @(posedge clock);
            ok &= line;
        end
        got.push_back({ok, c});
    end
endmodule
`default_nettype wire

// File: tb/displayed_value_serial_tx_tb.sv
// Testbench for the displayed value serial transmitter.
`default_nettype none
module displayed_value_serial_tx_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, reset_n = 0, sample_done = 0, value_negative = 0, overload = 0, rx_line = 1;
    logic [23:0] value_bcd = 24'h0;
    logic [2:0]  point_pos = 3'h0;
    wire         tx_line, busy;
    int          fails = 0, total_checks = 0;
    displayed_value_serial_tx #(.BIT_CYCLES(8)) i_dut (.clock(clock), .reset_n(reset_n),
        .sample_done(sample_done), .value_negative(value_negative), .value_bcd(value_bcd),
        .point_pos(point_pos), .overload(overload), .rx_line(rx_line), .tx_line(tx_line),
        .busy(busy));
    serial_rx_model #(.BIT(8)) i_rx (.clock(clock), .line(tx_line));
    initial forever #50 clock = ~clock;
    // Noise on the receive pin throughout; it must never alter output.
    always @(negedge clock) rx_line <= ~rx_line;
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Requests a frame, optionally pulsing twice more mid-frame, then compares characters.
    task automatic frame(string name, logic neg, logic [23:0] v, logic [2:0] pt, logic ov,
                         bit extra, string exp);
        {value_negative, value_bcd, point_pos, overload} = {neg, v, pt, ov};
        repeat (extra ? 3 : 1) begin
            sample_done = 1;
            @(negedge clock);
            sample_done = 0;
            repeat (extra ? 100 : 1) @(negedge clock);
        end
        for (int n = 0; n < 5000 && !(busy === 1'b0 && i_rx.got.size() >= exp.len()); n++)
            @(negedge clock);
        chk({name, " count"}, exp.len(), i_rx.got.size());
        for (int i = 0; i < exp.len(); i++) chk(name, 8'h80 | exp[i], i_rx.got[i]);
        i_rx.got.delete();
        $display("%s done", name);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clock);
        reset_n = 1;
        frame("plain", 0, 24'h001234, 3'h0, 0, 0, "WT,+001234\r\n");
        frame("point", 1, 24'h001234, 3'h1, 0, 0, "WT,-0123.4\r\n");
        frame("over", 0, 24'h001234, 3'h1, 1, 0, "OL,+9999.9\r\n");
        frame("range", 1, 24'h000056, 3'h7, 0, 0, "WT,-000056\r\n");
        frame("pending", 0, 24'h987654, 3'h2, 0, 1, {"WT,+876.54\r\n", "WT,+876.54\r\n"});
        repeat (60) @(negedge clock);
        chk("quiet", 8'h00, {7'h0, busy});
        conclude();
    end
    // Cuts a hang short well after the six frames should have finished.
    initial begin
        #3000000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
